// [inc/ptip_pkg.sv]
// Package for the test injection port: bit positions, codes, carriers
package ptip_pkg;

  localparam int TEST_IN_W        = 22;
  localparam int BIT_SIM          = 0;
  localparam int BIT_LPBK         = 1;
  localparam int BIT_NOSCRAM      = 2;
  localparam int BIT_FORCE_RXDET  = 3;
  localparam int BIT_BOOT         = 4;
  localparam int BIT_COMPL_DIS    = 5;
  localparam int BIT_COMPL_FORCE  = 6;
  localparam int BIT_NO_LOWPWR    = 7;
  localparam int ERR_LSB          = 8;
  localparam int LANE_LSB         = 11;
  localparam int BIT_RXERR_TLP    = 14;
  localparam int BIT_LCRC_TX      = 21;

  localparam logic [2:0] LANE_MAX   = 3'h3;
  localparam logic [2:0] TXST_IDLE  = 3'h0;
  localparam int         NUM_LANES  = 4;
  localparam logic       RST_BIT    = 1'b0;

  typedef enum logic [7:0] {
    PTIP_ERR_NONE   = 8'h01,
    PTIP_ERR_DATA   = 8'h02,
    PTIP_ERR_DISP   = 8'h04,
    PTIP_ERR_DIFF   = 8'h08,
    PTIP_ERR_SDP    = 8'h10,
    PTIP_ERR_STP    = 8'h20,
    PTIP_ERR_ENDDAT = 8'h40,
    PTIP_ERR_EDB    = 8'h80
  } ptip_err_t;

  typedef struct packed {
    logic sim_fast;
    logic lpbk_master;
    logic scram_off;
    logic force_rxdet;
    logic boot_skip_bar;
    logic compl_disable;
    logic compl_force;
    logic lowpwr_off;
  } ptip_mode_t;

  typedef struct packed {
    logic [NUM_LANES-1:0] lane_hit;
    ptip_err_t            err;
  } ptip_lane_err_t;

endpackage

// [rtl/ptip_flag.sv]
// One registered test flag with optional forcing and gating
`timescale 1ns/1ps
module ptip_flag (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic ce,
  // Flag
  input  wire logic req,
  input  wire logic force_on,
  input  wire logic allow,
  output logic      q
);
  logic d;
  assign d = (req | force_on) & allow;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= ptip_pkg::RST_BIT;
    end else if (ce) begin
      q <= d;
    end
  end
endmodule

// [rtl/ptip_top.sv]
// Test injection port: decodes the core's test input vector
`timescale 1ns/1ps
// Notes on behaviour
// - Bit 0 selects shortened simulation initialization
// - Bit 1 loopback master; reserved on x8
// - Bit 2 during init disables scrambling
// - Bit 3 forces receiver detect, guarded compliance
// - Bit 4 skips BAR check when booting remotely
// - Bits 6:5 disable or force compliance
// - Bit 7 blocks all low-power negotiation
// - Bits 10:8 pick the injected lane error
// - Bits 13:11 pick the target lane
// - Bit 14 fails LCRC of next received TLP; reserved on x8
// - Integrated transceiver forces bits 7 and 3
module ptip_top (
  // Clock and reset
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  input  wire logic                         ce,
  // Configuration
  input  wire logic                         cfg_x8,
  input  wire logic                         cfg_int_xcvr,
  // Test input vector and core state
  input  wire logic [21:0]                  test_in,
  input  wire logic [2:0]                   transmit_link_state_field,
  input  wire logic                         link_init_active,
  input  wire logic                         link_up,
  input  wire logic                         boot_behind,
  input  wire logic [ptip_pkg::NUM_LANES-1:0] lane_pattern_ok,
  // Mode outputs
  output ptip_pkg::ptip_mode_t              mode_q,
  output logic                              compl_allowed_q,
  // Injection outputs
  output ptip_pkg::ptip_lane_err_t          lane_err_q,
  output logic                              rx_lcrc_fail_q,
  output logic                              tx_lcrc_corrupt_q
);

  // Decoded requests
  wire       tx_active;
  wire       scram_req;
  wire       boot_req;
  wire       lpbk_req;
  wire       rxerr_req;
  wire [2:0] err_code;
  wire [2:0] lane_sel;
  wire       lane_ok;
  wire       lcrc_pulse;
  wire       any_pattern;

  assign tx_active  = transmit_link_state_field != ptip_pkg::TXST_IDLE;
  // Only a pulse while the transmitter is busy is acted upon
  assign lcrc_pulse = test_in[ptip_pkg::BIT_LCRC_TX] & tx_active;
  assign scram_req  = test_in[ptip_pkg::BIT_NOSCRAM] & link_init_active;
  assign boot_req   = test_in[ptip_pkg::BIT_BOOT] & ~link_up & boot_behind;
  assign lpbk_req   = test_in[ptip_pkg::BIT_LPBK] & ~cfg_x8;
  assign rxerr_req  = test_in[ptip_pkg::BIT_RXERR_TLP] & ~cfg_x8;
  assign err_code   = test_in[ptip_pkg::ERR_LSB +: 3];
  assign lane_sel   = test_in[ptip_pkg::LANE_LSB +: 3];
  assign lane_ok    = lane_sel <= ptip_pkg::LANE_MAX;
  assign any_pattern = |lane_pattern_ok;

  // Error kind, one-hot
  ptip_pkg::ptip_err_t err_d;
  always_comb begin
    case (err_code)
      3'h0:    err_d = ptip_pkg::PTIP_ERR_NONE;
      3'h1:    err_d = ptip_pkg::PTIP_ERR_DATA;
      3'h2:    err_d = ptip_pkg::PTIP_ERR_DISP;
      3'h3:    err_d = ptip_pkg::PTIP_ERR_DIFF;
      3'h4:    err_d = ptip_pkg::PTIP_ERR_SDP;
      3'h5:    err_d = ptip_pkg::PTIP_ERR_STP;
      3'h6:    err_d = ptip_pkg::PTIP_ERR_ENDDAT;
      3'h7:    err_d = ptip_pkg::PTIP_ERR_EDB;
      default: err_d = ptip_pkg::PTIP_ERR_NONE;
    endcase
  end

  // Bad lane select drops the whole request, not just the lane
  ptip_pkg::ptip_lane_err_t lane_err_d;
  assign lane_err_d.err      = lane_ok ? err_d : ptip_pkg::PTIP_ERR_NONE;
  assign lane_err_d.lane_hit = (lane_ok && err_code != 3'h0) ?
                               ptip_pkg::NUM_LANES'(4'h1 << lane_sel[1:0]) :
                               '0;

  // Flag cell outputs; the mode word gets a single driver below
  wire sim_fast_w;
  wire lpbk_master_w;
  wire scram_off_w;
  wire force_rxdet_w;
  wire boot_skip_bar_w;
  wire compl_disable_w;
  wire compl_force_w;
  wire lowpwr_off_w;

  // Mode flags through the shared flag cell
  ptip_flag u_sim (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ce       (ce),
    .req      (test_in[ptip_pkg::BIT_SIM]),
    .force_on (1'b0),
    .allow    (1'b1),
    .q        (sim_fast_w)
  );
  ptip_flag u_lpbk (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ce       (ce),
    .req      (lpbk_req),
    .force_on (1'b0),
    .allow    (1'b1),
    .q        (lpbk_master_w)
  );
  ptip_flag u_scram (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ce       (ce),
    .req      (scram_req),
    .force_on (1'b0),
    .allow    (1'b1),
    .q        (scram_off_w)
  );
  ptip_flag u_rxdet (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ce       (ce),
    .req      (test_in[ptip_pkg::BIT_FORCE_RXDET]),
    .force_on (cfg_int_xcvr),
    .allow    (1'b1),
    .q        (force_rxdet_w)
  );
  ptip_flag u_boot (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ce       (ce),
    .req      (boot_req),
    .force_on (1'b0),
    .allow    (1'b1),
    .q        (boot_skip_bar_w)
  );
  ptip_flag u_cdis (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ce       (ce),
    .req      (test_in[ptip_pkg::BIT_COMPL_DIS]),
    .force_on (1'b0),
    .allow    (1'b1),
    .q        (compl_disable_w)
  );
  // Disable wins over force when both are set
  ptip_flag u_cfrc (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ce       (ce),
    .req      (test_in[ptip_pkg::BIT_COMPL_FORCE]),
    .force_on (1'b0),
    .allow    (~test_in[ptip_pkg::BIT_COMPL_DIS]),
    .q        (compl_force_w)
  );
  ptip_flag u_lpwr (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .ce       (ce),
    .req      (test_in[ptip_pkg::BIT_NO_LOWPWR]),
    .force_on (cfg_int_xcvr),
    .allow    (1'b1),
    .q        (lowpwr_off_w)
  );

  // Pure wiring: every field is still a flop output
  assign mode_q = '{
    sim_fast:      sim_fast_w,
    lpbk_master:   lpbk_master_w,
    scram_off:     scram_off_w,
    force_rxdet:   force_rxdet_w,
    boot_skip_bar: boot_skip_bar_w,
    compl_disable: compl_disable_w,
    compl_force:   compl_force_w,
    lowpwr_off:    lowpwr_off_w
  };

  // Compliance entry gate
  wire compl_d;
  wire rxdet_eff;
  assign rxdet_eff = test_in[ptip_pkg::BIT_FORCE_RXDET] | cfg_int_xcvr;
  assign compl_d   = ~test_in[ptip_pkg::BIT_COMPL_DIS] &
                     (~rxdet_eff | any_pattern);

  // Lane error word; reset shows the normal-mode code
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lane_err_q <= '{lane_hit: '0, err: ptip_pkg::PTIP_ERR_NONE};
    end else if (ce) begin
      lane_err_q <= lane_err_d;
    end
  end

  // Receive LCRC failure request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_lcrc_fail_q <= ptip_pkg::RST_BIT;
    end else if (ce) begin
      rx_lcrc_fail_q <= rxerr_req;
    end
  end

  // No stretching: a one-cycle request stays one cycle wide
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_lcrc_corrupt_q <= ptip_pkg::RST_BIT;
    end else if (ce) begin
      tx_lcrc_corrupt_q <= lcrc_pulse & ~cfg_x8;
    end
  end

  // Compliance entry permission
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      compl_allowed_q <= ptip_pkg::RST_BIT;
    end else if (ce) begin
      compl_allowed_q <= compl_d;
    end
  end

endmodule

// [tb/ptip_top_asserts.sv]
// Checker on the test injection port outputs
`timescale 1ns/1ps
module ptip_top_asserts (
  // Clock, reset, inputs
  input logic                     mclk,
  input logic                     rst_b,
  input logic                     ce,
  input logic                     cfg_x8,
  input logic                     cfg_int_xcvr,
  input logic [21:0]              test_in,
  input logic [2:0]               transmit_link_state_field,
  // Outputs
  input ptip_pkg::ptip_mode_t     mode_q,
  input logic                     compl_allowed_q,
  input ptip_pkg::ptip_lane_err_t lane_err_q,
  input logic                     rx_lcrc_fail_q,
  input logic                     tx_lcrc_corrupt_q
);
  logic [21:0] t;
  logic [2:0]  s;
  logic        x;
  // Copies of the inputs one edge back, so slices need no $past
  always_ff @(posedge mclk) begin
    t <= test_in;
    s <= transmit_link_state_field;
    x <= cfg_x8;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_sim; ce |=> mode_q.sim_fast == t[0]; endproperty
  a_sim: assert property (p_sim) else $error("sim flag");
  property p_lpbk; ce |=> mode_q.lpbk_master == (t[1] && !x); endproperty
  a_lpbk: assert property (p_lpbk) else $error("loopback");
  property p_pwr; ce && cfg_int_xcvr |=> mode_q.lowpwr_off && mode_q.force_rxdet; endproperty
  a_pwr: assert property (p_pwr) else $error("xcvr force");
  property p_cmp; ce && test_in[5] |=> mode_q.compl_disable && !compl_allowed_q; endproperty
  a_cmp: assert property (p_cmp) else $error("compliance");
  property p_tx; ce |=> tx_lcrc_corrupt_q == (t[21] && s != 3'h0 && !x); endproperty
  a_tx: assert property (p_tx) else $error("tx lcrc");
  property p_rx; ce |=> rx_lcrc_fail_q == (t[14] && !x); endproperty
  a_rx: assert property (p_rx) else $error("rx lcrc");
  property p_err; ce && test_in[13:11] < 3'h4 |=> lane_err_q.err == 8'h01 << t[10:8]; endproperty
  a_err: assert property (p_err) else $error("err code");
  property p_bad; ce && test_in[13:11] > 3'h3 |=> lane_err_q == 12'h001; endproperty
  a_bad: assert property (p_bad) else $error("bad lane");
endmodule

bind ptip_top ptip_top_asserts u_chk (.mclk, .rst_b, .ce, .cfg_x8, .cfg_int_xcvr, .test_in,
  .transmit_link_state_field, .mode_q, .compl_allowed_q, .lane_err_q, .rx_lcrc_fail_q,
  .tx_lcrc_corrupt_q);

// [tb/ptip_partner.sv]
// User logic model that asks for one transmit LCRC corruption
`timescale 1ns/1ps
module ptip_partner (
  // Clock
  input logic       mclk,
  // Request and core state
  input logic       go,
  input logic [2:0] txst,
  // Pulse for test input bit 21
  output logic      pulse
);
  logic done;
  initial pulse = 1'b0;
  initial done = 1'b0;
  // Waits for a busy transmitter, then one pulse per request
  always @(negedge mclk) begin
    pulse <= go && !done && txst != 3'h0;
    done  <= go && (done || txst != 3'h0);
  end
endmodule

// [tb/test_ptip_top.sv]
// Self-checking bench for the test injection port
`timescale 1ns/1ps
module test_ptip_top;
  logic                     mclk = 0, rst_b = 0, ce = 1, go = 0, pulse, allow, rxf, txc;
  logic [4:0]               c = 0;
  logic [21:0]              tin = 0;
  logic [2:0]               txst = 0;
  logic [3:0]               ok = 0;
  ptip_pkg::ptip_mode_t     mode_q;
  ptip_pkg::ptip_lane_err_t lane_err_q;
  int                       n_fail = 0, check_count = 0, i;
  always #10 mclk = ~mclk;
  ptip_partner u_far (.mclk, .go, .txst, .pulse);
  ptip_top dut (.mclk, .rst_b, .ce, .cfg_x8(c[4]), .cfg_int_xcvr(c[3]),
    .test_in(tin | {pulse, 21'h0}), .transmit_link_state_field(txst), .link_init_active(c[2]),
    .link_up(c[1]), .boot_behind(c[0]), .lane_pattern_ok(ok), .mode_q, .compl_allowed_q(allow),
    .lane_err_q, .rx_lcrc_fail_q(rxf), .tx_lcrc_corrupt_q(txc));
  task chk(input string n, input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task results;
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // c is {x8, xcvr, init, up, boot}; e is {mode, allowed, rx fail}
  task t(input logic [21:0] v, input logic [4:0] cf, input logic [3:0] k, input logic [9:0] e);
    tin = v;
    c = cf;
    ok = k;
    @(negedge mclk);
    chk("mode", {mode_q, allow, rxf}, e);
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    rst_b = 1;
    for (i = 0; i < 64; i++) begin
      tin = 22'(i) << 8;
      @(negedge mclk);
      chk("lane", lane_err_q, i < 32 ? {(i % 8 != 0) ? 4'h1 << (i / 8) : 4'h0,
        8'h01 << (i % 8)} : 12'h001);
    end
    t(22'h0000ff, 5'h05, 4'h0, 10'h3f4);
    t(22'h000040, 5'h00, 4'h0, 10'h00a);
    t(22'h000008, 5'h00, 4'h0, 10'h040);
    t(22'h000008, 5'h00, 4'h2, 10'h042);
    t(22'h000000, 5'h08, 4'h0, 10'h044);
    t(22'h004006, 5'h10, 4'h0, 10'h002);
    t(22'h004014, 5'h03, 4'h0, 10'h003);
    t(22'h200000, 5'h00, 4'h0, 10'h002);
    chk("txc", txc, 12'h0);
    tin = 0;
    go <= 1'b1;
    repeat (2) @(negedge mclk);
    txst <= 3'h2;
    for (i = 0; i < 8 && txc !== 1'b1; i++) @(negedge mclk);
    chk("txc", txc, 12'h1);
    if (i == 8) results;
    @(negedge mclk);
    chk("txc", txc, 12'h0);
    go <= 1'b0;
    ce = 0;
    t(22'h000001, 5'h00, 4'h0, 10'h002);
    results;
  end
endmodule
